// ===== bench/fpt_assertions.sv
// bus and event checks on the fan block top ports
// assumes one master that holds each request until waitrequest is seen low
`timescale 1ns/1ps
`default_nettype none
module fpt_chk #(
  parameter int CLK_HZ = 250_000_000,
  parameter int OSC_HZ = 32_768
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [fpt_pkg::FPT_ADDR_W-1:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic avs_waitrequest_o,
  input wire logic fan_pwm_out_one_o,
  input wire logic fan_pwm_out_two_o,
  input wire logic power_event_signal_o,
  input wire logic smi_event_o
);
  import fpt_pkg::*;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  logic acc;
  logic pme_on, next_pme_on, smi_on, next_smi_on;
  // shadow enables track accepted writes so event outputs can be tied to them
  assign acc = avs_write_i && !avs_waitrequest_o && avs_byteenable_i[0];
  always_comb
  begin
    next_pme_on = pme_on;
    next_smi_on = smi_on;
    if (acc && avs_address_i == {FPT_IDX_PME_ENABLE, 2'b00})
      next_pme_on = |avs_writedata_i[3:0];
    if (acc && avs_address_i == {FPT_IDX_SMI_ENABLE, 2'b00})
      next_smi_on = |avs_writedata_i[3:0];
  end
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      pme_on <= 1'b0;
      smi_on <= 1'b0;
    end
    else
    begin
      pme_on <= next_pme_on;
      smi_on <= next_smi_on;
    end
  end
  property p_ack;
    (avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o;
  endproperty
  a_ack: assert property (p_ack) else $error("request not answered after one wait cycle");
  property p_one_low;
    $fell(avs_waitrequest_o) |=> avs_waitrequest_o;
  endproperty
  a_one_low: assert property (p_one_low) else $error("waitrequest low for more than one cycle");
  property p_idle_wait;
    !avs_read_i && !avs_write_i |=> avs_waitrequest_o;
  endproperty
  a_idle_wait: assert property (p_idle_wait) else $error("waitrequest low without request");
  property p_rd_upper;
    !avs_waitrequest_o |-> avs_readdata_o[31:8] == 24'h00_0000;
  endproperty
  a_rd_upper: assert property (p_rd_upper) else $error("read data upper bits not zero");
  property p_rd_idle;
    avs_waitrequest_o |-> avs_readdata_o == 32'h0000_0000;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not zero outside answer");
  property p_unmapped;
    !avs_waitrequest_o && avs_read_i && (avs_address_i < 10'h158 || avs_address_i > 10'h17C)
      |-> avs_readdata_o == 32'h0000_0000;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_rst_low;
    $rose(rst_n_i) |-> !fan_pwm_out_one_o && !fan_pwm_out_two_o;
  endproperty
  a_rst_low: assert property (p_rst_low) else $error("fan output high out of reset");
  property p_pme_en;
    power_event_signal_o |-> $past(pme_on);
  endproperty
  a_pme_en: assert property (p_pme_en) else $error("power event while disabled");
  property p_smi_en;
    smi_event_o |-> $past(smi_on);
  endproperty
  a_smi_en: assert property (p_smi_en) else $error("smi event while disabled");
  c_write: cover property (acc);
  c_pme: cover property ($rose(power_event_signal_o));
  c_smi: cover property ($rose(smi_event_o));
endmodule
bind fpt_top fpt_chk #(.CLK_HZ(CLK_HZ), .OSC_HZ(OSC_HZ)) fpt_chk_inst (
  .clk_i(clk_i),
  .rst_n_i(rst_n_i),
  .avs_address_i(avs_address_i),
  .avs_read_i(avs_read_i),
  .avs_write_i(avs_write_i),
  .avs_writedata_i(avs_writedata_i),
  .avs_byteenable_i(avs_byteenable_i),
  .avs_readdata_o(avs_readdata_o),
  .avs_waitrequest_o(avs_waitrequest_o),
  .fan_pwm_out_one_o(fan_pwm_out_one_o),
  .fan_pwm_out_two_o(fan_pwm_out_two_o),
  .power_event_signal_o(power_event_signal_o),
  .smi_event_o(smi_event_o)
);
`default_nettype wire

// ===== bench/fpt_fan_model.sv
// cooling fan model: spins when told and drives a square tachometer wave
// assumes the bench clock; a stopped rotor leaves the tach line resting low
`timescale 1ns/1ps
`default_nettype none
module fpt_fan_model #(
  parameter int HALF = 500
) (
  input wire logic clk_i,
  input wire logic run_i,
  output logic tach_o
);
  int cnt = 0;
  // restart from a low half on every spin-up, so the first rise comes HALF cycles later
  always_ff @(posedge clk_i)
  begin
    if (!run_i)
    begin
      cnt <= 0;
      tach_o <= 1'b0;
    end
    else if (cnt == HALF - 1)
    begin
      cnt <= 0;
      tach_o <= ~tach_o;
    end
    else
      cnt <= cnt + 1;
  end
endmodule
`default_nettype wire

// ===== bench/testbench.sv
// self-checking bench for the fan pwm and tachometer block
// assumes fpt_top behind avalon-mm with a fan model on each tach input
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import fpt_pkg::*;
  localparam int CLK = 250_000_000;
  localparam int OSC = 25_000_000; // ten clocks per tick
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [FPT_ADDR_W-1:0] avs_address_i = '0;
  logic avs_read_i = 1'b0;
  logic avs_write_i = 1'b0;
  logic [31:0] avs_writedata_i = 32'h0000_0000;
  logic [3:0] avs_byteenable_i = 4'h0;
  logic [31:0] avs_readdata_o;
  logic avs_waitrequest_o;
  logic run = 1'b0;
  logic tach_one, tach_two, pwm_one, pwm_two, pme, smi;
  int err_count = 0;
  int num_checks = 0;
  initial forever #2 clk_i = ~clk_i;
  fpt_top #(.CLK_HZ(CLK), .OSC_HZ(OSC)) fpt_top_inst (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
    .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
    .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o), .tach_one_i(tach_one),
    .tach_two_i(tach_two), .fan_pwm_out_one_o(pwm_one), .fan_pwm_out_two_o(pwm_two),
    .power_event_signal_o(pme), .smi_event_o(smi));
  fpt_fan_model #(.HALF(500)) fan_one (.clk_i(clk_i), .run_i(run), .tach_o(tach_one));
  fpt_fan_model #(.HALF(700)) fan_two (.clk_i(clk_i), .run_i(run), .tach_o(tach_two));
  task automatic give_verdict();
    if (err_count == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("[FAIL] %s expected %0h seen %0h", name, exp, got);
    end
  endtask
  task automatic chk_rng(input string name, input int lo, input int hi, input logic [31:0] got);
    num_checks++;
    if ($isunknown(got) || got < lo || got > hi)
    begin
      err_count++;
      $display("[FAIL] %s expected %0d..%0d seen %0d", name, lo, hi, got);
    end
  endtask
  // one avalon transfer; the request is held until waitrequest is sampled low
  task automatic xfer(input logic wr, input logic [7:0] idx, input logic [7:0] wd, output logic [7:0] rd);
    int n;
    @(posedge clk_i);
    avs_address_i <= {idx, 2'b00};
    avs_writedata_i <= {24'h00_0000, wd};
    avs_byteenable_i <= 4'h1;
    avs_write_i <= wr;
    avs_read_i <= ~wr;
    n = 0;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (avs_waitrequest_o !== 1'b0 && n < 50);
    rd = avs_readdata_o[7:0];
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
    if (n >= 50)
    begin
      chk("bus_timeout", 0, 1);
      give_verdict();
    end
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] wd);
    logic [7:0] d;
    xfer(1'b1, idx, wd, d);
  endtask
  task automatic rd_chk(input string name, input logic [7:0] idx, input logic [7:0] exp);
    logic [7:0] d;
    xfer(1'b0, idx, 8'h00, d);
    chk(name, {24'h00_0000, exp}, {24'h00_0000, d});
  endtask
  task automatic rd_rng(input string name, input logic [7:0] idx, input int lo, input int hi);
    logic [7:0] d;
    xfer(1'b0, idx, 8'h00, d);
    chk_rng(name, lo, hi, {24'h00_0000, d});
  endtask
  // period and high time of fan output one, between its second and third rise
  task automatic meas(output int per, output int hi);
    int n, r;
    logic prev;
    n = 0;
    r = 0;
    per = 0;
    hi = 0;
    prev = pwm_one;
    while (r < 3 && n < 40000)
    begin
      @(posedge clk_i);
      n++;
      if (pwm_one === 1'b1 && prev === 1'b0)
        r++;
      if (r == 2)
      begin
        per++;
        hi += (pwm_one === 1'b1);
      end
      prev = pwm_one;
    end
    if (r < 3)
    begin
      chk("pwm_timeout", 0, 1);
      give_verdict();
    end
  endtask
  task automatic lvl(output int hi);
    hi = 0;
    repeat (1000)
    begin
      @(posedge clk_i);
      hi += (pwm_one === 1'b1);
    end
  endtask
  initial
  begin
    int per, hi, p;
    repeat (10) @(posedge clk_i);
    rst_n_i <= 1'b1;
    rd_chk("drive_one_rst", FPT_IDX_DRIVE_ONE, FPT_DRIVE_RST);
    rd_chk("control_rst", FPT_IDX_CONTROL, FPT_CONTROL_RST);
    rd_chk("unmapped", 8'h10, 8'h00);
    lvl(hi);
    chk("pwm_rst_low", 0, hi);
    wr(FPT_IDX_DRIVE_TWO, 8'hA5);
    rd_chk("drive_two", FPT_IDX_DRIVE_TWO, 8'hA5);
    chk("force_two", 1, pwm_two);
    wr(FPT_IDX_TACH_ONE, 8'h33);
    rd_chk("tach_ro", FPT_IDX_TACH_ONE, 8'h00);
    wr(FPT_IDX_DRIVE_ONE, 8'hC0);
    meas(per, hi);
    p = CLK * 2 / (FPT_PWM_OUTPUT_WAVE_FAST_HI_X2_HZ);
    chk_rng("period_sel", p - 4, p + 4, per);
    chk_rng("high_half", p / 2 - p / 32, p / 2 + p / 32, hi);
    wr(FPT_IDX_CONTROL, 8'h58);
    meas(per, hi);
    p = CLK / FPT_PWM_OUTPUT_WAVE_FAST_HI_X2_HZ;
    chk_rng("period_mult", p - 4, p + 4, per);
    wr(FPT_IDX_DRIVE_ONE, 8'hFE);
    meas(per, hi);
    chk_rng("high_max", p * 63 / 64 - p / 32, p * 63 / 64 + p / 32, hi);
    chk_rng("low_max", 1, p / 32, per - hi);
    wr(FPT_IDX_DRIVE_ONE, 8'h80);
    repeat (6000) @(posedge clk_i);
    lvl(hi);
    chk("duty_zero", 0, hi);
    wr(FPT_IDX_DRIVE_ONE, 8'h81);
    repeat (6000) @(posedge clk_i);
    lvl(hi);
    chk("force_high", 1000, hi);
    wr(FPT_IDX_PRELOAD_ONE, 8'd32);
    run <= 1'b1;
    for (int c = 0; c < 4; c++)
    begin
      wr(FPT_IDX_CONTROL, {c[1:0], 6'b010000});
      repeat (3500) @(posedge clk_i);
      p = 1000 / (10 << c) + 32;
      rd_rng("tach_div", FPT_IDX_TACH_ONE, p - 2, p + 2);
    end
    rd_rng("tach_two", FPT_IDX_TACH_TWO, 68, 72);
    wr(FPT_IDX_CONTROL, 8'h10);
    wr(FPT_IDX_PRELOAD_ONE, 8'd100);
    repeat (3500) @(posedge clk_i);
    rd_rng("tach_thr", FPT_IDX_TACH_ONE, 198, 202);
    rd_chk("status_thr", FPT_IDX_EVT_STATUS, 8'h01);
    chk("pme_masked", 0, pme);
    wr(FPT_IDX_PME_ENABLE, 8'h01);
    repeat (3) @(posedge clk_i);
    chk("pme_on", 1, pme);
    chk("smi_masked", 0, smi);
    wr(FPT_IDX_SMI_ENABLE, 8'h01);
    repeat (3) @(posedge clk_i);
    chk("smi_on", 1, smi);
    run <= 1'b0;
    repeat (3000) @(posedge clk_i);
    rd_chk("tach_sat", FPT_IDX_TACH_ONE, FPT_TACH_MAX);
    wr(FPT_IDX_EVT_STATUS, 8'h0F);
    rd_chk("status_clr", FPT_IDX_EVT_STATUS, 8'h00);
    run <= 1'b1;
    repeat (1000) @(posedge clk_i);
    rd_chk("tach_hold", FPT_IDX_TACH_ONE, FPT_TACH_MAX);
    give_verdict();
  end
endmodule
`default_nettype wire

// ===== rtl/fpt_pkg.sv
// fan pwm and tachometer block: shared constants, types and decode helpers
// assumes a single 250 MHz clock and Avalon-MM byte addressing of word registers
package fpt_pkg;

  // register indices; byte address is four times the index
  localparam logic [7:0] FPT_IDX_DRIVE_ONE = 8'h56;
  localparam logic [7:0] FPT_IDX_DRIVE_TWO = 8'h57;
  localparam logic [7:0] FPT_IDX_CONTROL = 8'h58;
  localparam logic [7:0] FPT_IDX_PRELOAD_ONE = 8'h59;
  localparam logic [7:0] FPT_IDX_PRELOAD_TWO = 8'h5A;
  localparam logic [7:0] FPT_IDX_TACH_ONE = 8'h5B;
  localparam logic [7:0] FPT_IDX_TACH_TWO = 8'h5C;
  localparam logic [7:0] FPT_IDX_EVT_STATUS = 8'h5D;
  localparam logic [7:0] FPT_IDX_PME_ENABLE = 8'h5E;
  localparam logic [7:0] FPT_IDX_SMI_ENABLE = 8'h5F;
  localparam int FPT_ADDR_W = 10;

  // reset values
  localparam logic [7:0] FPT_DRIVE_RST = 8'h00;
  localparam logic [7:0] FPT_CONTROL_RST = 8'h50;
  localparam logic [7:0] FPT_PRELOAD_RST = 8'h00;
  localparam logic [3:0] FPT_EVT_RST = 4'h0;

  // tachometer limits
  localparam logic [7:0] FPT_TACH_THRESHOLD = 8'hC0;
  localparam logic [7:0] FPT_TACH_MAX = 8'hFF;

  // control register field positions; the divisor field has one entry per fan
  localparam int FPT_CTL_SRC_LSB = 0;
  localparam int FPT_CTL_MUL_LSB = 2;
  localparam int FPT_CTL_DIV_HI_LSB = 6;
  localparam int FPT_CTL_DIV_LO_LSB = 4;

  // pwm output wave rates: 64 slots per output period, in Hz
  localparam int FPT_SLOTS = 64;
  localparam int FPT_PWM_OUTPUT_WAVE_FAST_LO_HZ = 15625;
  localparam int FPT_PWM_OUTPUT_WAVE_FAST_HI_X2_HZ = 46875;
  localparam int FPT_PWM_OUTPUT_WAVE_SLOW_LO_HZ = 40;
  localparam int FPT_PWM_OUTPUT_WAVE_SLOW_HI_HZ = 60;

  typedef struct packed {
    logic clk_sel;
    logic [5:0] duty_code;
    logic force_high;
  } fpt_drive_t;

  typedef struct packed {
    logic src_slow;
    logic mult;
  } fpt_clk_cfg_t;

  typedef enum logic [1:0] {
    FPT_TACH_IDLE = 2'b00,
    FPT_TACH_COUNT = 2'b01,
    FPT_TACH_HELD = 2'b11
  } fpt_tach_state_t;

  // divisor code 00/01/10/11 -> 1/2/4/8, returned as terminal count of the prescaler
  function automatic logic [2:0] fpt_div_last(input logic [1:0] code);
    case (code)
      2'b00: fpt_div_last = 3'h0;
      2'b01: fpt_div_last = 3'h1;
      2'b10: fpt_div_last = 3'h3;
      default: fpt_div_last = 3'h7;
    endcase
  endfunction

endpackage

// ===== rtl/fpt_pwm.sv
// one fan pwm channel: fractional slot timebase and 64-slot duty comparator
// assumes drive and clock config are stable register outputs of the parent
`timescale 1ns/1ps
`default_nettype none
module fpt_pwm #(
  parameter int CLK_HZ = 250_000_000
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire fpt_pkg::fpt_drive_t drive_i,
  input wire fpt_pkg::fpt_clk_cfg_t cfg_i,
  output logic pwm_o
);
  import fpt_pkg::*;

  logic [31:0] acc;
  logic [31:0] next_acc;
  logic [5:0] slot;
  logic [5:0] next_slot;
  logic next_pwm;
  logic [31:0] rate;

  always_comb
  begin
    // slot rate is 64 times the output frequency, doubled by the multiplier
    case ({cfg_i.src_slow, drive_i.clk_sel}) // [R05] [R06]
      2'b00: rate = 32'(FPT_SLOTS * FPT_PWM_OUTPUT_WAVE_FAST_LO_HZ);
      2'b01: rate = 32'(FPT_SLOTS * FPT_PWM_OUTPUT_WAVE_FAST_HI_X2_HZ / 2);
      2'b10: rate = 32'(FPT_SLOTS * FPT_PWM_OUTPUT_WAVE_SLOW_LO_HZ);
      default: rate = 32'(FPT_SLOTS * FPT_PWM_OUTPUT_WAVE_SLOW_HI_HZ);
    endcase
    if (cfg_i.mult)
    begin
      rate = rate << 1; // [R07]
    end
    next_slot = slot;
    if (acc + rate >= 32'(CLK_HZ))
    begin
      next_acc = acc + rate - 32'(CLK_HZ);
      next_slot = slot + 6'h01;
    end
    else
    begin
      next_acc = acc + rate;
    end
    // duty code zero never beats the slot count; code 63 leaves slot 63 low
    if (drive_i.force_high)
    begin
      next_pwm = 1'b1; // [R04]
    end
    else
    begin
      next_pwm = (next_slot < drive_i.duty_code); // [R01] [R02] [R03]
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      acc <= 32'h0000_0000;
      slot <= 6'h00;
      pwm_o <= 1'b0; // [R19]
    end
    else
    begin
      acc <= next_acc;
      slot <= next_slot;
      pwm_o <= next_pwm;
    end
  end
endmodule
`default_nettype wire

// ===== rtl/fpt_tach.sv
// one tachometer channel: input sync, divided counter, capture and event pulses
// assumes osc_tick_i is a one-cycle pulse at the 32.768 kHz oscillator rate
`timescale 1ns/1ps
`default_nettype none
module fpt_tach (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic osc_tick_i,
  input wire logic [1:0] div_code_i,
  input wire logic [7:0] preload_i,
  input wire logic preload_wr_i,
  input wire logic tach_i,
  output logic [7:0] captured_o,
  output logic thr_evt_o,
  output logic sat_evt_o
);
  import fpt_pkg::*;

  logic sync_a, sync_b, prev;
  logic [2:0] div_cnt, next_div_cnt;
  logic [7:0] cnt, next_cnt, next_captured;
  logic next_thr, next_sat, rise, tick;
  fpt_tach_state_t state, next_state;

  assign rise = sync_b & ~prev; // [R21]

  always_comb
  begin
    next_div_cnt = div_cnt;
    tick = 1'b0;
    if (osc_tick_i)
    begin
      if (div_cnt >= fpt_div_last(div_code_i)) // [R08] [R10] [R20]
      begin
        next_div_cnt = 3'h0;
        tick = 1'b1;
      end
      else
      begin
        next_div_cnt = div_cnt + 3'h1;
      end
    end
    next_cnt = cnt;
    next_captured = captured_o;
    next_state = state;
    next_thr = 1'b0;
    next_sat = 1'b0;
    case (state)
      FPT_TACH_IDLE:
      begin
        if (rise)
        begin
          next_state = FPT_TACH_COUNT;
        end
      end
      FPT_TACH_COUNT:
      begin
        if (rise)
        begin
          next_captured = cnt; // [R13]
          next_thr = (cnt >= FPT_TACH_THRESHOLD); // [R14]
        end
        else if (tick && (cnt + 8'h01 == FPT_TACH_MAX || cnt == FPT_TACH_MAX))
        begin
          next_captured = FPT_TACH_MAX; // [R15]
          next_sat = 1'b1;
          next_state = FPT_TACH_HELD;
        end
        else if (tick)
        begin
          next_cnt = cnt + 8'h01; // [R12]
        end
      end
      FPT_TACH_HELD:
      begin
        if (rise)
        begin
          next_state = FPT_TACH_COUNT;
        end
      end
      default: next_state = FPT_TACH_IDLE;
    endcase
    if (rise || preload_wr_i || (next_state == FPT_TACH_HELD))
    begin
      next_cnt = preload_i; // [R11] [R12] [R17]
    end
    if (preload_wr_i && (state != FPT_TACH_HELD))
    begin
      next_state = FPT_TACH_COUNT;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      sync_a <= 1'b0;
      sync_b <= 1'b0;
      prev <= 1'b0;
      div_cnt <= 3'h0;
      cnt <= FPT_PRELOAD_RST;
      captured_o <= FPT_PRELOAD_RST;
      thr_evt_o <= 1'b0;
      sat_evt_o <= 1'b0;
      state <= FPT_TACH_IDLE;
    end
    else
    begin
      sync_a <= tach_i;
      sync_b <= sync_a;
      prev <= sync_b;
      div_cnt <= next_div_cnt;
      cnt <= next_cnt;
      captured_o <= next_captured;
      thr_evt_o <= next_thr;
      sat_evt_o <= next_sat;
      state <= next_state;
    end
  end
endmodule
`default_nettype wire

// ===== rtl/fpt_top.sv
// fan pwm and tachometer block top: Avalon-MM register slave, oscillator tick, two fan channels
// assumes a 250 MHz clock, asynchronous tach inputs and a single Avalon master
//
// Overview of operation
// [R01] duty code in drive bits 6..1 gives a high fraction of code/64.
// [R02] duty code zero keeps the fan output low.
// [R03] duty code 63 keeps output high for 63 of 64 slots.
// [R04] drive bit 0 set forces the fan output high regardless of duty code.
// [R05] drive bit 7 with control source and multiplier bits picks output frequency.
// [R06] unmultiplied rates are 15.625k/23.438k fast or 40/60 Hz slow.
// [R07] multiplier bit 3 or 2 doubles the selected output rate.
// [R08] divisor fields bits 7-6 and 5-4 divide the counting clock by 1,2,4,8.
// [R09] after reset each divisor selects divide by two.
// [R10] tach counter clocks from a divider fed by the 32.768 kHz oscillator.
// [R11] counter restarts on tach rising edge, on 0xFF, and on preload write.
// [R12] on tach edge counter loads preload then counts divided pulses.
// [R13] a tach edge captures the counter into the tach register first.
// [R14] captured count of 192 or more raises a power event.
// [R15] reaching 0xFF captures 0xFF, raises a second event, holds until next pulse.
// [R16] event outputs fire only when their enable bit is set.
// [R17] each fan has its own writable preload register.
// [R18] drive registers at index 0x56, 0x57; control at index 0x58.
// [R19] fan outputs come out of reset driven low.
// [R20] divisor codes 00,01,10,11 mean divide by 1,2,4,8.
// [R21] tach inputs are synchronised before edge detection, one capture per edge.
//
// Our own choice: the Avalon-MM slave port.
`timescale 1ns/1ps
`default_nettype none
module fpt_top #(
  parameter int CLK_HZ = 250_000_000,
  parameter int OSC_HZ = 32_768
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [fpt_pkg::FPT_ADDR_W-1:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire logic tach_one_i,
  input wire logic tach_two_i,
  output logic fan_pwm_out_one_o,
  output logic fan_pwm_out_two_o,
  output logic power_event_signal_o,
  output logic smi_event_o
);
  import fpt_pkg::*;

  // register storage
  fpt_drive_t drive [2];
  fpt_drive_t next_drive [2];
  logic [7:0] control;
  logic [7:0] next_control;
  logic [7:0] preload [2];
  logic [7:0] next_preload [2];
  logic [1:0] preload_wr;
  logic [1:0] next_preload_wr;
  logic [3:0] evt_status;
  logic [3:0] next_evt_status;
  logic [3:0] pme_enable;
  logic [3:0] next_pme_enable;
  logic [3:0] smi_enable;
  logic [3:0] next_smi_enable;

  // bus handshake state
  logic next_waitrequest;
  logic [31:0] next_readdata;
  logic bus_req;
  logic bus_accept;
  logic wr_lane0;
  logic [7:0] wbyte;

  // oscillator tick
  logic [31:0] osc_acc;
  logic [31:0] next_osc_acc;
  logic osc_tick;
  logic next_osc_tick;

  // channel wiring
  logic [1:0] tach_in;
  logic [1:0] pwm_wave;
  logic [7:0] captured [2];
  logic [1:0] thr_evt;
  logic [1:0] sat_evt;
  logic [3:0] evt_set;
  logic next_power_event;
  logic next_smi_event;

  // true when the byte address selects the word at register index idx
  function automatic logic fpt_hit(input logic [FPT_ADDR_W-1:0] addr, input logic [7:0] idx);
    fpt_hit = (addr == {idx, 2'b00});
  endfunction

  assign bus_req = avs_read_i | avs_write_i;
  assign bus_accept = bus_req & ~avs_waitrequest_o;
  assign wr_lane0 = avs_write_i & bus_accept & avs_byteenable_i[0];
  assign wbyte = avs_writedata_i[7:0];
  assign tach_in = {tach_two_i, tach_one_i};
  assign evt_set = {sat_evt, thr_evt};

  // waitrequest drops for exactly one cycle after a request is seen
  always_comb
  begin
    next_waitrequest = 1'b1;
    if (bus_req && avs_waitrequest_o)
    begin
      next_waitrequest = 1'b0;
    end
  end

  // read data is prepared while waitrequest is high, so it stands at the accepting edge
  always_comb
  begin
    next_readdata = 32'h0000_0000;
    if (avs_read_i && avs_waitrequest_o)
    begin
      if (fpt_hit(avs_address_i, FPT_IDX_DRIVE_ONE)) // [R18]
      begin
        next_readdata[7:0] = drive[0];
      end
      else if (fpt_hit(avs_address_i, FPT_IDX_DRIVE_TWO))
      begin
        next_readdata[7:0] = drive[1];
      end
      else if (fpt_hit(avs_address_i, FPT_IDX_CONTROL))
      begin
        next_readdata[7:0] = control;
      end
      else if (fpt_hit(avs_address_i, FPT_IDX_PRELOAD_ONE))
      begin
        next_readdata[7:0] = preload[0];
      end
      else if (fpt_hit(avs_address_i, FPT_IDX_PRELOAD_TWO))
      begin
        next_readdata[7:0] = preload[1];
      end
      else if (fpt_hit(avs_address_i, FPT_IDX_TACH_ONE))
      begin
        next_readdata[7:0] = captured[0]; // [R13]
      end
      else if (fpt_hit(avs_address_i, FPT_IDX_TACH_TWO))
      begin
        next_readdata[7:0] = captured[1];
      end
      else if (fpt_hit(avs_address_i, FPT_IDX_EVT_STATUS))
      begin
        next_readdata[3:0] = evt_status;
      end
      else if (fpt_hit(avs_address_i, FPT_IDX_PME_ENABLE))
      begin
        next_readdata[3:0] = pme_enable;
      end
      else if (fpt_hit(avs_address_i, FPT_IDX_SMI_ENABLE))
      begin
        next_readdata[3:0] = smi_enable;
      end
      else
      begin
        next_readdata = 32'h0000_0000;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      avs_waitrequest_o <= 1'b1;
      avs_readdata_o <= 32'h0000_0000;
    end
    else
    begin
      avs_waitrequest_o <= next_waitrequest;
      avs_readdata_o <= next_readdata;
    end
  end

  // writable registers; only byte lane 0 carries data, unmapped writes are dropped
  always_comb
  begin
    next_drive[0] = drive[0];
    next_drive[1] = drive[1];
    next_control = control;
    next_preload[0] = preload[0];
    next_preload[1] = preload[1];
    next_preload_wr = 2'b00;
    next_pme_enable = pme_enable;
    next_smi_enable = smi_enable;
    if (wr_lane0)
    begin
      if (fpt_hit(avs_address_i, FPT_IDX_DRIVE_ONE)) // [R18]
      begin
        next_drive[0] = wbyte;
      end
      if (fpt_hit(avs_address_i, FPT_IDX_DRIVE_TWO))
      begin
        next_drive[1] = wbyte;
      end
      if (fpt_hit(avs_address_i, FPT_IDX_CONTROL))
      begin
        next_control = wbyte;
      end
      if (fpt_hit(avs_address_i, FPT_IDX_PRELOAD_ONE))
      begin
        next_preload[0] = wbyte; // [R17]
        next_preload_wr[0] = 1'b1; // [R11]
      end
      if (fpt_hit(avs_address_i, FPT_IDX_PRELOAD_TWO))
      begin
        next_preload[1] = wbyte;
        next_preload_wr[1] = 1'b1;
      end
      if (fpt_hit(avs_address_i, FPT_IDX_PME_ENABLE))
      begin
        next_pme_enable = wbyte[3:0];
      end
      if (fpt_hit(avs_address_i, FPT_IDX_SMI_ENABLE))
      begin
        next_smi_enable = wbyte[3:0];
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      drive[0] <= FPT_DRIVE_RST;
      drive[1] <= FPT_DRIVE_RST;
      control <= FPT_CONTROL_RST; // [R09]
      preload[0] <= FPT_PRELOAD_RST;
      preload[1] <= FPT_PRELOAD_RST;
      preload_wr <= 2'b00;
      pme_enable <= FPT_EVT_RST;
      smi_enable <= FPT_EVT_RST;
    end
    else
    begin
      drive[0] <= next_drive[0];
      drive[1] <= next_drive[1];
      control <= next_control;
      preload[0] <= next_preload[0];
      preload[1] <= next_preload[1];
      preload_wr <= next_preload_wr;
      pme_enable <= next_pme_enable;
      smi_enable <= next_smi_enable;
    end
  end

  // sticky event flags, write one to clear; a new event in the clearing cycle survives
  always_comb
  begin
    next_evt_status = evt_status;
    if (wr_lane0 && fpt_hit(avs_address_i, FPT_IDX_EVT_STATUS))
    begin
      next_evt_status = evt_status & ~wbyte[3:0];
    end
    next_evt_status = next_evt_status | evt_set; // [R14] [R15]
    next_power_event = |(evt_status & pme_enable); // [R16]
    next_smi_event = |(evt_status & smi_enable); // [R16]
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      evt_status <= FPT_EVT_RST;
      power_event_signal_o <= 1'b0;
      smi_event_o <= 1'b0;
    end
    else
    begin
      evt_status <= next_evt_status;
      power_event_signal_o <= next_power_event;
      smi_event_o <= next_smi_event;
    end
  end

  // fractional accumulator: the 32.768 kHz rate does not divide 250 MHz evenly,
  // so ticks jitter by one clock but average exactly to the oscillator rate
  always_comb
  begin
    next_osc_tick = 1'b0;
    if (osc_acc + 32'(OSC_HZ) >= 32'(CLK_HZ))
    begin
      next_osc_acc = osc_acc + 32'(OSC_HZ) - 32'(CLK_HZ);
      next_osc_tick = 1'b1; // [R10]
    end
    else
    begin
      next_osc_acc = osc_acc + 32'(OSC_HZ);
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      osc_acc <= 32'h0000_0000;
      osc_tick <= 1'b0;
    end
    else
    begin
      osc_acc <= next_osc_acc;
      osc_tick <= next_osc_tick;
    end
  end

  // two identical fan channels
  for (genvar g = 0; g < 2; g++)
  begin : gen_fan
    fpt_clk_cfg_t clk_cfg;
    logic [1:0] div_code;

    assign clk_cfg.src_slow = control[FPT_CTL_SRC_LSB + g]; // [R05]
    assign clk_cfg.mult = control[FPT_CTL_MUL_LSB + 1 - g]; // [R07]
    assign div_code = (g == 0) ? control[FPT_CTL_DIV_HI_LSB +: 2] : control[FPT_CTL_DIV_LO_LSB +: 2]; // [R08]

    fpt_pwm #(
      .CLK_HZ(CLK_HZ)
    ) u_pwm (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .drive_i(drive[g]),
      .cfg_i(clk_cfg),
      .pwm_o(pwm_wave[g])
    );

    fpt_tach u_tach (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .osc_tick_i(osc_tick),
      .div_code_i(div_code),
      .preload_i(preload[g]),
      .preload_wr_i(preload_wr[g]),
      .tach_i(tach_in[g]),
      .captured_o(captured[g]),
      .thr_evt_o(thr_evt[g]),
      .sat_evt_o(sat_evt[g])
    );
  end

  // pwm waves come straight from the channel flip-flops
  assign fan_pwm_out_one_o = pwm_wave[0]; // [R19]
  assign fan_pwm_out_two_o = pwm_wave[1];

endmodule
`default_nettype wire
